// *** rtl/pdmc_params.svh ***
// Constants of the power-down mode controller
`ifndef PDMC_PARAMS_SVH
`define PDMC_PARAMS_SVH
`define PDMC_STS_8K 3'h0
`define PDMC_STS_16K 3'h1
`define PDMC_STS_32K 3'h2
`define PDMC_STS_64K 3'h3
`define PDMC_STS_128K 3'h4
`define PDMC_STS_EXT 3'h5
`define PDMC_STS_8 3'h6
`define PDMC_STS_16 3'h7
`define PDMC_WAIT_8K 18'h02000
`define PDMC_WAIT_16K 18'h04000
`define PDMC_WAIT_32K 18'h08000
`define PDMC_WAIT_64K 18'h10000
`define PDMC_WAIT_128K 18'h20000
`define PDMC_WAIT_2 18'h00002
`define PDMC_WAIT_8 18'h00008
`define PDMC_WAIT_16 18'h00010
`define PDMC_MDIV_RESET 2'h3
`define PDMC_SYNC_MAX 2
`endif

// *** rtl/pdmc_pkg.sv ***
// Types of the power-down mode controller
package pdmc_pkg;
  typedef enum logic [2:0] {
    PDMC_ACT_HS, PDMC_ACT_MS, PDMC_SUBACT, PDMC_SLEEP_HS, PDMC_SLEEP_MS,
    PDMC_STANDBY, PDMC_WATCH, PDMC_SUBSLEEP
  } pdmc_mode_t;
  typedef struct packed {
    logic standby_select;
    logic low_speed_select;
    logic medium_speed_select;
    logic direct_transfer_select;
    logic watch_clock_select;
    logic [2:0] settling_wait_field;
    logic medium_divider_select_hi;
    logic medium_divider_select_lo;
  } pdmc_ctrl_t;
  // Enabled wake requests grouped by source
  typedef struct packed {
    logic timer_a;
    logic timer_c;
    logic timer_f;
    logic timer_g;
    logic async_event_counter;
    logic serial_port_one;
    logic serial_port_two;
    logic converter;
    logic other_periph;
    logic [4:0] external_interrupt_lines;
    logic [7:0] wakeup_pins;
  } pdmc_wake_t;
endpackage

// *** rtl/pdmc_sync.sv ***
// Three-stage synchroniser with second/third stage agreement
module pdmc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// *** rtl/pdmc_ctrl.sv ***
// What this block does
// - Enabled interrupt in sleep wakes to matching-speed active with exception handling.
// - No interrupt wake while global mask is set or source is disabled.
// - Wake synchronising adds at most two clock periods; the pin synchroniser here takes up to four before pins_sync follows.
// - Clear pin low in sleep leaves sleep and resets the CPU.
// - Medium-speed sleep clocks peripherals at selected divided rate.
// - Sleep with standby, no low-speed, no watch clock enters standby.
// - Standby exits only on lines 1 and 0, wakeup pins, clear pin.
// - Standby interrupt wake counts settling wait then resumes by medium select.
// - Clear low in standby starts oscillator; reset handling after release.
// - Settling field codes map to 8192..131072, 2, 8, 16 states.
// - Falling edge counts only after two cycles of prior high.
// - Sleep with standby and watch clock selects enters watch mode.
// - Watch exits on timers A F G, line 0, wakeup pins, clear.
// - Watch wake targets high, medium or subactive; active waits settling.
// - Sleep in subactive with low-speed and watch clock, no standby: subsleep.
// - Subsleep exits on timers, counter, serial ports, lines 4-0, pins, clear.
// - Enabled wake in subsleep returns to subactive with exception handling.
// - Subactive sleep with standby and watch clock goes to watch.
// - Sleep exits on any peripheral interrupt or the clear pin.
// - Clear low in watch, subsleep, subactive behaves as in standby.
// - Active sleep with all selects zero enters high-speed sleep.
// - Medium divider codes select oscillator divided by 16, 32, 64, 128.
`include "pdmc_params.svh"
module pdmc_ctrl
  import pdmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleep_exec,
  input wire pdmc_ctrl_t ctrl,
  input wire logic ccr_int_mask,
  input wire pdmc_wake_t wake_req,
  input wire logic [12:0] ext_pins_raw,
  input wire logic external_clear_pin_n,
  output pdmc_mode_t mode,
  output logic cpu_halt,
  output logic periph_halt,
  output logic osc_enable,
  output logic clock_supply,
  output logic io_float,
  output logic [7:0] periph_div,
  output logic irq_exception,
  output logic reset_exception,
  output logic cpu_reset,
  output logic [12:0] ext_fall
);
  pdmc_mode_t mode_q;
  pdmc_mode_t mode_d;
  pdmc_mode_t target_q;
  logic settling_q;
  logic [17:0] wait_cnt_q;
  logic [17:0] wait_len;
  logic clr_sync_n;
  logic clear_hold_q;
  logic [12:0] pins_sync;
  logic [12:0] pins_prev_q;
  logic [1:0] high_cnt_q [13];
  logic wake_any;
  logic wake_sleep;
  logic wake_standby;
  logic wake_watch;
  logic wake_subsleep;
  logic settle_done;
  logic gate_ok;
  logic clr_pin_low;
  logic clr_low_sync;

  // External clear and trigger pins arrive asynchronously
  // Clear is carried in its asserted sense: the synchroniser resets to 0,
  // which must mean no clear, or every reset would fake a clear pulse
  assign clr_pin_low = !external_clear_pin_n;

  pdmc_sync #(.W(1)) u_clr_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(clr_pin_low),
    .dout(clr_low_sync)
  );

  assign clr_sync_n = !clr_low_sync;

  pdmc_sync #(.W(13)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(ext_pins_raw),
    .dout(pins_sync)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins_prev_q <= '0;
      ext_fall <= '0;
      for (int i = 0; i < 13; i++) begin
        high_cnt_q[i] <= 2'h0;
      end
    end else begin
      pins_prev_q <= pins_sync;
      for (int i = 0; i < 13; i++) begin
        ext_fall[i] <= pins_prev_q[i] && !pins_sync[i] && (high_cnt_q[i] >= 2'h2);
        if (pins_sync[i]) begin
          if (high_cnt_q[i] != 2'h3) begin
            high_cnt_q[i] <= high_cnt_q[i] + 2'h1;
          end
        end else begin
          high_cnt_q[i] <= 2'h0;
        end
      end
    end
  end

  // mask gate; wake_req is already per-source enabled
  assign gate_ok = !ccr_int_mask;
  assign wake_any = |wake_req;
  assign wake_sleep = gate_ok && wake_any;
  assign wake_standby = gate_ok && (|wake_req.external_interrupt_lines[1:0]
                        || |wake_req.wakeup_pins);
  assign wake_watch = gate_ok && (wake_req.timer_a || wake_req.timer_f || wake_req.timer_g
                      || wake_req.external_interrupt_lines[0] || |wake_req.wakeup_pins);
  assign wake_subsleep = gate_ok && (wake_req.timer_a || wake_req.timer_c
                         || wake_req.timer_f || wake_req.timer_g
                         || wake_req.async_event_counter || wake_req.serial_port_one
                         || wake_req.serial_port_two
                         || |wake_req.external_interrupt_lines || |wake_req.wakeup_pins);

  always_comb begin
    case (ctrl.settling_wait_field)
      `PDMC_STS_8K: wait_len = `PDMC_WAIT_8K;
      `PDMC_STS_16K: wait_len = `PDMC_WAIT_16K;
      `PDMC_STS_32K: wait_len = `PDMC_WAIT_32K;
      `PDMC_STS_64K: wait_len = `PDMC_WAIT_64K;
      `PDMC_STS_128K: wait_len = `PDMC_WAIT_128K;
      `PDMC_STS_EXT: wait_len = `PDMC_WAIT_2;
      `PDMC_STS_8: wait_len = `PDMC_WAIT_8;
      default: wait_len = `PDMC_WAIT_16;
    endcase
  end

  assign settle_done = settling_q && (wait_cnt_q == wait_len - 18'h1);

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PDMC_ACT_HS, PDMC_ACT_MS: begin
        if (sleep_exec) begin
          if (ctrl.standby_select && ctrl.watch_clock_select) begin
            mode_d = PDMC_WATCH;
          end else if (ctrl.standby_select && !ctrl.low_speed_select) begin
            mode_d = PDMC_STANDBY;
          end else if (!ctrl.standby_select && !ctrl.low_speed_select
                       && !ctrl.direct_transfer_select) begin
            mode_d = ctrl.medium_speed_select ? PDMC_SLEEP_MS : PDMC_SLEEP_HS;
          end
        end
      end
      PDMC_SUBACT: begin
        if (sleep_exec && ctrl.watch_clock_select) begin
          if (ctrl.standby_select) begin
            mode_d = PDMC_WATCH;
          end else if (ctrl.low_speed_select) begin
            mode_d = PDMC_SUBSLEEP;
          end
        end
      end
      // sleep returns to matching active speed
      PDMC_SLEEP_HS: if (wake_sleep) begin
        mode_d = PDMC_ACT_HS;
      end
      PDMC_SLEEP_MS: if (wake_sleep) begin
        mode_d = PDMC_ACT_MS;
      end
      PDMC_STANDBY: if (settle_done) begin
        mode_d = target_q;
      end
      PDMC_WATCH: begin
        if (!settling_q && wake_watch && ctrl.low_speed_select) begin
          mode_d = PDMC_SUBACT;
        end else if (settle_done) begin
          mode_d = target_q;
        end
      end
      PDMC_SUBSLEEP: if (wake_subsleep) begin
        mode_d = PDMC_SUBACT;
      end
      default: mode_d = PDMC_ACT_HS;
    endcase
  end

  // clear pin forces reset state; handled by clr_sync_n
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= PDMC_ACT_MS;
    end else if (!clr_sync_n) begin
      mode_q <= PDMC_ACT_MS;
    end else begin
      mode_q <= mode_d;
    end
  end

  // settling counter restarts on oscillator restart
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settling_q <= 1'b0;
      wait_cnt_q <= 18'h0;
      target_q <= PDMC_ACT_HS;
    end else if (!clr_sync_n) begin
      settling_q <= 1'b0;
      wait_cnt_q <= 18'h0;
    end else if (!settling_q && ((mode_q == PDMC_STANDBY && wake_standby)
                 || (mode_q == PDMC_WATCH && wake_watch && !ctrl.low_speed_select))) begin
      settling_q <= 1'b1;
      wait_cnt_q <= 18'h0;
      target_q <= ctrl.medium_speed_select ? PDMC_ACT_MS : PDMC_ACT_HS;
    end else if (settle_done) begin
      settling_q <= 1'b0;
    end else if (settling_q) begin
      wait_cnt_q <= wait_cnt_q + 18'h1;
    end
  end

  // reset handling waits for the clear pin release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clear_hold_q <= 1'b0;
      reset_exception <= 1'b0;
    end else begin
      clear_hold_q <= !clr_sync_n;
      reset_exception <= clear_hold_q && clr_sync_n;
    end
  end

  // interrupt handling pulse on wake completion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_exception <= 1'b0;
    end else begin
      irq_exception <= clr_sync_n && (mode_d != mode_q)
                       && (mode_q inside {PDMC_SLEEP_HS, PDMC_SLEEP_MS, PDMC_STANDBY,
                                          PDMC_WATCH, PDMC_SUBSLEEP});
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      periph_div <= 8'h80;
    end else begin
      case ({ctrl.medium_divider_select_hi, ctrl.medium_divider_select_lo})
        2'h0: periph_div <= 8'h10;
        2'h1: periph_div <= 8'h20;
        2'h2: periph_div <= 8'h40;
        default: periph_div <= 8'h80;
      endcase
    end
  end

  assign mode = mode_q;
  assign cpu_reset = clear_hold_q;
  assign cpu_halt = !(mode_q inside {PDMC_ACT_HS, PDMC_ACT_MS, PDMC_SUBACT});
  // standby stops everything and floats pins
  assign periph_halt = mode_q inside {PDMC_STANDBY, PDMC_WATCH, PDMC_SUBSLEEP};
  assign io_float = (mode_q == PDMC_STANDBY);
  // Oscillator runs out of standby/watch, while settling, or under clear
  assign osc_enable = !(mode_q inside {PDMC_STANDBY, PDMC_WATCH}) || settling_q
                      || clear_hold_q;
  // no clock to the chip before terminal count
  assign clock_supply = osc_enable && !settling_q;

  property p_mask_blocks;
    @(posedge clk) disable iff (!rst_n)
      (ccr_int_mask && clr_sync_n && mode_q == PDMC_SLEEP_HS) |=> mode_q == PDMC_SLEEP_HS;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked wake left sleep");

  sequence s_settle_start;
    settling_q && wait_cnt_q == 18'h0;
  endsequence
  property p_settle_gate;
    @(posedge clk) disable iff (!rst_n || !clr_sync_n)
      s_settle_start ##0 (wait_len == `PDMC_WAIT_8) |-> !clock_supply [*7];
  endproperty
  a_settle_gate: assert property (p_settle_gate) else $error("clock given early");

  property p_sleep_wake;
    @(posedge clk) disable iff (!rst_n)
      (mode_q == PDMC_SLEEP_MS && wake_sleep && clr_sync_n) |=> mode_q == PDMC_ACT_MS;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("wrong sleep exit");

  property p_clear_reset;
    @(posedge clk) disable iff (!rst_n)
      !clr_sync_n |=> mode_q == PDMC_ACT_MS && !settling_q;
  endproperty
  a_clear_reset: assert property (p_clear_reset) else $error("clear not honoured");

  // Standby wake opens the settling window with the clock still held back
  sequence s_standby_wake;
    mode_q == PDMC_STANDBY && !settling_q && wake_standby && clr_sync_n;
  endsequence
  property p_standby_settle;
    @(posedge clk) disable iff (!rst_n)
      s_standby_wake |=> settling_q && osc_enable && !clock_supply && mode_q == PDMC_STANDBY;
  endproperty
  a_standby_settle: assert property (p_standby_settle) else $error("no settling on wake");

  // Low-speed watch wake goes straight to subactive
  sequence s_watch_low_wake;
    mode_q == PDMC_WATCH && !settling_q && wake_watch && ctrl.low_speed_select && clr_sync_n;
  endsequence
  property p_watch_subact;
    @(posedge clk) disable iff (!rst_n)
      s_watch_low_wake |=> mode_q == PDMC_SUBACT;
  endproperty
  a_watch_subact: assert property (p_watch_subact) else $error("no subactive exit");

  property p_subsleep_wake;
    @(posedge clk) disable iff (!rst_n)
      (mode_q == PDMC_SUBSLEEP && wake_subsleep && clr_sync_n) |=> mode_q == PDMC_SUBACT;
  endproperty
  a_subsleep_wake: assert property (p_subsleep_wake) else $error("subsleep exit missed");

  // Release after a clear: one reset exception and the CPU reset drops
  sequence s_clear_release;
    clear_hold_q && clr_sync_n;
  endsequence
  property p_clear_release;
    @(posedge clk) disable iff (!rst_n)
      s_clear_release |=> reset_exception && !cpu_reset;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("no reset exception");
endmodule

// *** sim/pdmc_far_model.sv ***
// Far-side model: external wake pins and the clear pin
module pdmc_far_model #(
  parameter int STABLE_CYC = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [12:0] pin_cmd,
  input wire logic clr_cmd,
  input wire logic osc_enable,
  output logic [12:0] ext_pins_raw,
  output logic external_clear_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] held_q;
  logic [7:0] osc_cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_pins_raw <= 13'h1fff;
      held_q <= 4'h0;
    end else if (pin_cmd != ext_pins_raw && held_q >= 4'h2) begin
      ext_pins_raw <= pin_cmd;
      held_q <= 4'h0;
    end else if (held_q != 4'hf) begin
      held_q <= held_q + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      external_clear_pin_n <= 1'b1;
      osc_cnt_q <= 8'h00;
    end else begin
      if (clr_cmd) begin
        external_clear_pin_n <= 1'b0;
      end else if (osc_cnt_q >= 8'(STABLE_CYC)) begin
        external_clear_pin_n <= 1'b1;
      end
      if (external_clear_pin_n) begin
        osc_cnt_q <= 8'h00;
      end else if (osc_enable && osc_cnt_q != 8'hff) begin
        osc_cnt_q <= osc_cnt_q + 8'h01;
      end
    end
  end
endmodule

// *** sim/power_down_mode_controller_tb.sv ***
// Self-checking bench for the power-down mode controller
module power_down_mode_controller_tb
  import pdmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TA = 21, TC = 20, SP1 = 16, IRQ1 = 9, IRQ0 = 8;
  logic clk, rst_n, sleep_exec, ccr_int_mask, clr_cmd, external_clear_pin_n;
  pdmc_ctrl_t ctrl;
  pdmc_wake_t wake_req;
  logic [12:0] pin_cmd, ext_pins_raw, ext_fall;
  pdmc_mode_t mode;
  logic cpu_halt, periph_halt, osc_enable, clock_supply, io_float;
  logic [7:0] periph_div;
  logic irq_exception, reset_exception, cpu_reset;
  int errors, samples_checked, cycles, irq_cnt, rex_cnt, fall_cnt, n, base;
  int wk_src[4] = '{0, IRQ1, IRQ0, 7};
  // code 101 stands for an external clock source
  logic [2:0] sts_code[4] = '{3'h5, 3'h6, 3'h7, 3'h0};
  int wait_len[4] = '{2, 8, 16, 8192};

  pdmc_ctrl pdmc_ctrl_inst (.clk(clk), .rst_n(rst_n), .sleep_exec(sleep_exec), .ctrl(ctrl),
    .ccr_int_mask(ccr_int_mask), .wake_req(wake_req), .ext_pins_raw(ext_pins_raw),
    .external_clear_pin_n(external_clear_pin_n), .mode(mode), .cpu_halt(cpu_halt),
    .periph_halt(periph_halt), .osc_enable(osc_enable), .clock_supply(clock_supply),
    .io_float(io_float), .periph_div(periph_div), .irq_exception(irq_exception),
    .reset_exception(reset_exception), .cpu_reset(cpu_reset), .ext_fall(ext_fall));
  pdmc_far_model pdmc_far_model_inst (.clk(clk), .rst_n(rst_n), .pin_cmd(pin_cmd),
    .clr_cmd(clr_cmd), .osc_enable(osc_enable), .ext_pins_raw(ext_pins_raw),
    .external_clear_pin_n(external_clear_pin_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checked=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Ceiling covers the 8192-state settling run with wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      give_verdict();
    end
  end

  always @(posedge clk) begin
    if (irq_exception === 1'b1) irq_cnt++;
    if (reset_exception === 1'b1) rex_cnt++;
    if (ext_fall[5] === 1'b1) fall_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic set_ctrl(input logic sb, ls, ms, wc, input logic [2:0] sts,
                          input logic [1:0] dv);
    ctrl = '{sb, ls, ms, 1'b0, wc, sts, dv[1], dv[0]};
  endtask

  task automatic do_sleep();
    sleep_exec = 1'b1;
    step(1);
    sleep_exec = 1'b0;
    step(1);
  endtask

  task automatic wake(input int bit_idx, input int k);
    wake_req = pdmc_wake_t'(22'h1 << bit_idx);
    step(k);
    wake_req = '0;
    // Let an edge see the idle request before the next call
    step(1);
  endtask

  task automatic wait_mode(input pdmc_mode_t m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      step(1);
      n++;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    sleep_exec = 1'b0;
    // Divider select starts at its initial code 11
    set_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 2'h3);
    ccr_int_mask = 1'b0;
    wake_req = '0;
    pin_cmd = 13'h1fff;
    clr_cmd = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(5);
    check(32'(mode), 32'(PDMC_ACT_MS));
    check(32'(periph_div), 32'h80);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      set_ctrl(1'b0, 1'b0, 1'b1, 1'b0, 3'h6, 2'(c));
      do_sleep();
      check(32'(mode), 32'(PDMC_SLEEP_MS));
      check(32'(periph_div), 32'h10 << c);
      check(32'(cpu_halt), 32'h1);
      check(32'(periph_halt), 32'h0);
      base = irq_cnt;
      wake(TA, 1);
      wait_mode(PDMC_ACT_MS, 4);
      check(32'(mode), 32'(PDMC_ACT_MS));
      check(32'(cpu_halt), 32'h0);
      step(2);
      check(32'(irq_cnt - base), 32'h1);
      set_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 3'h6, 2'(c));
      do_sleep();
      check(32'(mode), 32'(PDMC_SLEEP_HS));
      ccr_int_mask = 1'b1;
      wake(TA, 4);
      check(32'(mode), 32'(PDMC_SLEEP_HS));
      ccr_int_mask = 1'b0;
      wake(SP1, 1);
      wait_mode(PDMC_ACT_HS, 4);
      check(32'(mode), 32'(PDMC_ACT_HS));
    end
    $display("test sleep done");
    for (int i = 0; i < 4; i++) begin
      set_ctrl(1'b1, 1'b0, 1'(i % 2), 1'b0, sts_code[i], 2'h3);
      do_sleep();
      check(32'(mode), 32'(PDMC_STANDBY));
      check(32'(io_float), 32'h1);
      check(32'(periph_halt), 32'h1);
      wake(TA, 3);
      check(32'(mode), 32'(PDMC_STANDBY));
      wake(wk_src[i], 1);
      check(32'(osc_enable), 32'h1);
      check(32'(clock_supply), 32'h0);
      wait_mode((i % 2) ? PDMC_ACT_MS : PDMC_ACT_HS, 9000);
      check(32'(mode), 32'((i % 2) ? PDMC_ACT_MS : PDMC_ACT_HS));
      if (i == 0) base = n;
      else check(32'(n - base), 32'(wait_len[i] - 2));
    end
    $display("test standby done");
    set_ctrl(1'b1, 1'b0, 1'b0, 1'b1, 3'h6, 2'h3);
    do_sleep();
    check(32'(mode), 32'(PDMC_WATCH));
    wake(TC, 3);
    check(32'(mode), 32'(PDMC_WATCH));
    set_ctrl(1'b1, 1'b1, 1'b0, 1'b1, 3'h6, 2'h3);
    wake(TA, 1);
    wait_mode(PDMC_SUBACT, 4);
    check(32'(mode), 32'(PDMC_SUBACT));
    set_ctrl(1'b0, 1'b1, 1'b0, 1'b1, 3'h6, 2'h3);
    do_sleep();
    check(32'(mode), 32'(PDMC_SUBSLEEP));
    wake(SP1, 1);
    wait_mode(PDMC_SUBACT, 4);
    check(32'(mode), 32'(PDMC_SUBACT));
    set_ctrl(1'b1, 1'b1, 1'b0, 1'b1, 3'h6, 2'h3);
    do_sleep();
    check(32'(mode), 32'(PDMC_WATCH));
    $display("test watch done");
    base = fall_cnt;
    pin_cmd = 13'h1fdf;
    step(12);
    check(32'(fall_cnt - base), 32'h1);
    pin_cmd = 13'h1fff;
    step(6);
    clr_cmd = 1'b1;
    step(6);
    check(32'(cpu_reset), 32'h1);
    check(32'(mode), 32'(PDMC_ACT_MS));
    base = rex_cnt;
    clr_cmd = 1'b0;
    n = 0;
    while (external_clear_pin_n !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    step(8);
    check(32'(rex_cnt - base), 32'h1);
    check(32'(cpu_reset), 32'h0);
    $display("test clear done");
    give_verdict();
  end
endmodule
